// [drvpl_top.sv]
// Purpose: Rate word, channel gain, sample holding and PLL control behind AXI4-Lite
// Assumes: aclk is the crystal clock; pll_lock_in is synchronous to aclk
// Notes: Registers are 16 bits in the low half of each 32-bit word
//
// Overview of operation
// - Rate word is high nibble above low half
// - Sample strobe rate is word times clock over 2^27
// - High register bits 12:11 and 9:4 control the PLL
// - Left and right samples are read-write registers
// - Fine field adds 0 to 5.5 dB
// - Coarse field attenuates 6 dB per step
// - Crystal clock halved before PLL input
// - PLL multiplier is rate field plus one
// - Zero rate powers VCO down, selects input clock
// - Clock-select bit picks VCO or input clock
// - Input-halving bit halves PLL input again
// - VCO-to-pin bit routes VCO to pin
// - Lock-test bit high sets lock flag
// - Losing lock with test bit low clears flag until next test
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns

module drvpl_top
    import drvpl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_lock_in,
    output logic [19:0] combined_rate_word,
    output logic sample_strobe,
    output logic [15:0] left_out,
    output logic [15:0] right_out,
    output logic pll_ref_clk,
    output logic [4:0] pll_multiplier,
    output logic vco_enable,
    output logic select_vco,
    output logic oscillator_to_pin,
    output logic irq
);

    // ==========================================================
    // Functions
    // Byte lane merge of the low 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Fine gain factor in Q12, half-decibel steps, clamped at 5.5 dB
    function automatic logic [13:0] fine_factor(input logic [3:0] f);
        case ((f > DRVPL_FINE_MAX) ? DRVPL_FINE_MAX : f)
            4'h0: fine_factor = 14'h1000;
            4'h1: fine_factor = 14'h10f3;
            4'h2: fine_factor = 14'h11f4;
            4'h3: fine_factor = 14'h1304;
            4'h4: fine_factor = 14'h1425;
            4'h5: fine_factor = 14'h1556;
            4'h6: fine_factor = 14'h169a;
            4'h7: fine_factor = 14'h17f1;
            4'h8: fine_factor = 14'h195c;
            4'h9: fine_factor = 14'h1adc;
            4'ha: fine_factor = 14'h1c74;
            default: fine_factor = 14'h1e23;
        endcase
    endfunction

    // Coarse shift then fine multiply, saturated to 16 bits
    function automatic logic [15:0] scale(input logic [15:0] smp, input drvpl_gain_t g);
        logic signed [15:0] shifted;
        logic signed [30:0] prod;
        logic signed [18:0] q;
        shifted = $signed(smp) >>> g.coarse;
        prod = 31'(shifted * $signed({1'b0, fine_factor(g.fine)}));
        q = prod[30:12];
        if (q > 19'sd32767) begin
            scale = 16'h7fff;
        end else if (q < -19'sd32768) begin
            scale = 16'h8000;
        end else begin
            scale = q[15:0];
        end
    endfunction

    // ==========================================================
    // State
    logic [15:0] rate_low_reg, rate_high_reg, left_reg, right_reg, gain_reg, left_out_reg, right_out_reg;
    logic lock_flag_reg, div2_reg, aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg, arready_reg;
    logic rvalid_reg, sample_strobe_reg, pll_ref_clk_reg, vco_enable_reg, select_vco_reg, vco_pin_reg, irq_reg;
    logic [DRVPL_IRQ_BITS-1:0] irq_status_reg;
    logic [DRVPL_IRQ_BITS-1:0] irq_mask_reg;
    logic [DRVPL_ACC_BITS-1:0] acc_reg;
    logic [29:0] aw_idx_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [4:0] mult_reg;
    logic [19:0] rate_word_reg;

    // ==========================================================
    // Field decode
    wire [19:0] rate_word = {rate_high_reg[DRVPL_RATE_HI_LSB +: 4], rate_low_reg};
    drvpl_pll_t pll;
    assign pll.rate = rate_high_reg[DRVPL_PLL_RATE_LSB +: 4];
    assign pll.div_inclk = rate_high_reg[DRVPL_DIV_INCLK_BIT];
    assign pll.force_vco = rate_high_reg[DRVPL_FORCE_VCO_BIT];
    assign pll.vco_to_pin = rate_high_reg[DRVPL_VCO_PIN_BIT];
    assign pll.set_lock = rate_high_reg[DRVPL_SET_LOCK_BIT];
    drvpl_gain_t left_gain;
    drvpl_gain_t right_gain;
    assign left_gain = gain_reg[15:8];
    assign right_gain = gain_reg[7:0];
    wire [15:0] high_read = (rate_high_reg & DRVPL_HIGH_WR_MASK) | (16'(lock_flag_reg) << DRVPL_LOCKED_BIT);

    // ==========================================================
    // AXI write path
    wire aw_fire = s_axi_awvalid && awready_reg;
    wire w_fire = s_axi_wvalid && wready_reg;
    wire have_aw = aw_hold_reg || aw_fire;
    wire have_w = w_hold_reg || w_fire;
    wire do_write = have_aw && have_w;
    wire [29:0] wr_idx = aw_fire ? s_axi_awaddr[31:2] : aw_idx_reg;
    wire [31:0] wr_data = w_fire ? s_axi_wdata : w_data_reg;
    wire [3:0] wr_strb = w_fire ? s_axi_wstrb : w_strb_reg;
    wire aw_hold_next = have_aw && !do_write;
    wire w_hold_next = have_w && !do_write;
    wire bvalid_next = do_write || (bvalid_reg && !s_axi_bready);

    // Write strobes per register
    wire wr_low = do_write && (wr_idx == DRVPL_IDX_RATE_LOW);
    wire wr_high = do_write && (wr_idx == DRVPL_IDX_RATE_HIGH);
    wire wr_left = do_write && (wr_idx == DRVPL_IDX_LEFT);
    wire wr_right = do_write && (wr_idx == DRVPL_IDX_RIGHT);
    wire wr_gain = do_write && (wr_idx == DRVPL_IDX_GAIN);
    wire wr_stat = do_write && (wr_idx == DRVPL_IDX_IRQ_STATUS);
    wire wr_mask = do_write && (wr_idx == DRVPL_IDX_IRQ_MASK);
    wire wr_hit = wr_low || wr_high || wr_left || wr_right || wr_gain || wr_stat || wr_mask;

    // Handshake and response registers for writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= DRVPL_RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awready_reg <= !aw_hold_next && !bvalid_next;
            wready_reg <= !w_hold_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_hit ? DRVPL_RESP_OKAY : DRVPL_RESP_SLVERR;
            end
        end
    end

    // Captured address and data while waiting for the partner channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_reg <= 30'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_idx_reg <= s_axi_awaddr[31:2];
            end
            if (w_fire) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // ==========================================================
    // AXI read path
    wire ar_fire = s_axi_arvalid && arready_reg;
    wire [29:0] rd_idx = s_axi_araddr[31:2];
    wire rvalid_next = ar_fire || (rvalid_reg && !s_axi_rready);
    wire rd_hit_low = rd_idx == DRVPL_IDX_RATE_LOW;
    wire rd_hit_high = rd_idx == DRVPL_IDX_RATE_HIGH;
    wire rd_hit_left = rd_idx == DRVPL_IDX_LEFT;
    wire rd_hit_right = rd_idx == DRVPL_IDX_RIGHT;
    wire rd_hit_gain = rd_idx == DRVPL_IDX_GAIN;
    wire rd_hit_stat = rd_idx == DRVPL_IDX_IRQ_STATUS;
    wire rd_hit_mask = rd_idx == DRVPL_IDX_IRQ_MASK;
    wire rd_hit = rd_hit_low || rd_hit_high || rd_hit_left || rd_hit_right || rd_hit_gain || rd_hit_stat || rd_hit_mask;
    logic [15:0] rd_val;

    // Read multiplexer
    always_comb begin
        if (rd_hit_low) begin
            rd_val = rate_low_reg;
        end else if (rd_hit_high) begin
            rd_val = high_read;
        end else if (rd_hit_left) begin
            rd_val = left_reg;
        end else if (rd_hit_right) begin
            rd_val = right_reg;
        end else if (rd_hit_gain) begin
            rd_val = gain_reg;
        end else if (rd_hit_stat) begin
            rd_val = 16'(irq_status_reg);
        end else if (rd_hit_mask) begin
            rd_val = 16'(irq_mask_reg);
        end else begin
            rd_val = 16'h0000;
        end
    end

    // Handshake and data registers for reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= DRVPL_RESP_OKAY;
        end else begin
            arready_reg <= !rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_fire) begin
                rdata_reg <= {16'h0000, rd_val};
                rresp_reg <= rd_hit ? DRVPL_RESP_OKAY : DRVPL_RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Software registers
    wire [15:0] high_wr_val = merge16(rate_high_reg, wr_data, wr_strb) & DRVPL_HIGH_WR_MASK;

    // Rate, sample and gain registers, all zero after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_low_reg <= DRVPL_REG_RESET;
            rate_high_reg <= DRVPL_REG_RESET;
            left_reg <= DRVPL_REG_RESET;
            right_reg <= DRVPL_REG_RESET;
            gain_reg <= DRVPL_REG_RESET;
            irq_mask_reg <= '0;
        end else begin
            if (wr_low) begin
                rate_low_reg <= merge16(rate_low_reg, wr_data, wr_strb);
            end
            if (wr_high) begin
                rate_high_reg <= high_wr_val;
            end
            if (wr_left) begin
                left_reg <= merge16(left_reg, wr_data, wr_strb);
            end
            if (wr_right) begin
                right_reg <= merge16(right_reg, wr_data, wr_strb);
            end
            if (wr_gain) begin
                gain_reg <= merge16(gain_reg, wr_data, wr_strb);
            end
            if (wr_mask && wr_strb[0]) begin
                irq_mask_reg <= wr_data[DRVPL_IRQ_BITS-1:0];
            end
        end
    end

    // ==========================================================
    // Lock test flag
    // Test bit forces the flag high; a loss of lock while the test bit is low clears it until the next test
    wire lock_next = pll.set_lock ? 1'b1 : (lock_flag_reg && pll_lock_in);
    wire lock_lost = lock_flag_reg && !lock_next;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_flag_reg <= 1'b0;
        end else begin
            lock_flag_reg <= lock_next;
        end
    end

    // ==========================================================
    // Interrupts
    // Out-of-range rate word written, checked on the value after the write
    wire [19:0] rate_after = {wr_high ? high_wr_val[3:0] : rate_high_reg[3:0],
                              wr_low ? merge16(rate_low_reg, wr_data, wr_strb) : rate_low_reg};
    wire range_event = (wr_low || wr_high) && (rate_after > DRVPL_RATE_MAX);
    wire [DRVPL_IRQ_BITS-1:0] irq_set = {range_event, lock_lost};
    wire [DRVPL_IRQ_BITS-1:0] irq_clr = (wr_stat && wr_strb[0]) ? wr_data[DRVPL_IRQ_BITS-1:0] : '0;
    wire [DRVPL_IRQ_BITS-1:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

    // Sticky status, set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_reg <= |(irq_status_next & irq_mask_reg);
        end
    end

    // ==========================================================
    // Sample rate generator and channel gain
    wire [DRVPL_ACC_BITS:0] acc_sum = {1'b0, acc_reg} + {8'h00, rate_word};

    // Phase accumulator overflows C times per 2^27 clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= '0;
            sample_strobe_reg <= 1'b0;
            left_out_reg <= 16'h0000;
            right_out_reg <= 16'h0000;
            rate_word_reg <= 20'h00000;
        end else begin
            acc_reg <= acc_sum[DRVPL_ACC_BITS-1:0];
            sample_strobe_reg <= acc_sum[DRVPL_ACC_BITS];
            rate_word_reg <= rate_word;
            if (acc_sum[DRVPL_ACC_BITS]) begin
                left_out_reg <= scale(left_reg, left_gain);
                right_out_reg <= scale(right_reg, right_gain);
            end
        end
    end

    // ==========================================================
    // PLL input divider and clock controls
    wire vco_on = pll.rate != 4'h0;
    wire ref_hold = pll.div_inclk && div2_reg;

    // Reference toggles every clock, or every other one when halving; a mode change never stretches a level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div2_reg <= 1'b0;
            pll_ref_clk_reg <= 1'b0;
            mult_reg <= 5'h01;
            vco_enable_reg <= 1'b0;
            select_vco_reg <= 1'b0;
            vco_pin_reg <= 1'b0;
        end else begin
            div2_reg <= !div2_reg;
            pll_ref_clk_reg <= ref_hold ? pll_ref_clk_reg : !pll_ref_clk_reg;
            mult_reg <= {1'b0, pll.rate} + 5'h01;
            vco_enable_reg <= vco_on;
            select_vco_reg <= pll.force_vco && vco_on;
            vco_pin_reg <= pll.vco_to_pin;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign combined_rate_word = rate_word_reg;
    assign sample_strobe = sample_strobe_reg;
    assign left_out = left_out_reg;
    assign right_out = right_out_reg;
    assign pll_ref_clk = pll_ref_clk_reg;
    assign pll_multiplier = mult_reg;
    assign vco_enable = vco_enable_reg;
    assign select_vco = select_vco_reg;
    assign oscillator_to_pin = vco_pin_reg;
    assign irq = irq_reg;

endmodule

// [drvpl_pkg.sv]
// Purpose: Shared constants and types for the rate, gain and PLL control block
// Assumes: Register indexes are word indexes; byte address is four times the index
// Notes: All software register reset values are zero
package drvpl_pkg;

    // ==========================================================
    // Register word indexes
    localparam logic [29:0] DRVPL_IDX_RATE_LOW = 30'h0000c013;
    localparam logic [29:0] DRVPL_IDX_RATE_HIGH = 30'h0000c014;
    localparam logic [29:0] DRVPL_IDX_LEFT = 30'h0000c015;
    localparam logic [29:0] DRVPL_IDX_RIGHT = 30'h0000c016;
    localparam logic [29:0] DRVPL_IDX_GAIN = 30'h0000c045;
    localparam logic [29:0] DRVPL_IDX_IRQ_STATUS = 30'h0000c0f0;
    localparam logic [29:0] DRVPL_IDX_IRQ_MASK = 30'h0000c0f1;

    // ==========================================================
    // Field positions of the high rate and PLL register
    localparam int DRVPL_RATE_HI_LSB = 0;
    localparam int DRVPL_PLL_RATE_LSB = 4;
    localparam int DRVPL_DIV_INCLK_BIT = 8;
    localparam int DRVPL_FORCE_VCO_BIT = 9;
    localparam int DRVPL_VCO_PIN_BIT = 11;
    localparam int DRVPL_SET_LOCK_BIT = 12;
    localparam int DRVPL_LOCKED_BIT = 13;
    localparam logic [15:0] DRVPL_HIGH_WR_MASK = 16'h1bff;

    // ==========================================================
    // Rate word limits and reset values
    localparam logic [19:0] DRVPL_RATE_MAX = 20'h80000;
    localparam int DRVPL_ACC_BITS = 27;
    localparam logic [15:0] DRVPL_REG_RESET = 16'h0000;
    localparam logic [3:0] DRVPL_FINE_MAX = 4'hb;
    localparam int DRVPL_GAIN_FRAC = 12;

    // Interrupt status bits
    localparam int DRVPL_IRQ_LOCK_LOST = 0;
    localparam int DRVPL_IRQ_RATE_RANGE = 1;
    localparam int DRVPL_IRQ_BITS = 2;

    // AXI responses
    localparam logic [1:0] DRVPL_RESP_OKAY = 2'h0;
    localparam logic [1:0] DRVPL_RESP_SLVERR = 2'h2;

    // Per-channel gain fields
    typedef struct packed {
        logic [3:0] fine;
        logic [3:0] coarse;
    } drvpl_gain_t;

    // PLL control fields as seen by the clock logic
    typedef struct packed {
        logic [3:0] rate;
        logic div_inclk;
        logic force_vco;
        logic vco_to_pin;
        logic set_lock;
    } drvpl_pll_t;

endpackage

// [drvpl_monitor.sv]
// Purpose: Port-level checks for the rate, gain and PLL control block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every drvpl_top instance
`timescale 1ns/1ns
module drvpl_monitor
    import drvpl_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [19:0] combined_rate_word,
    input logic sample_strobe,
    input logic pll_ref_clk,
    input logic [4:0] pll_multiplier,
    input logic vco_enable,
    input logic select_vco
);
    // ==========================================================
    // Clocking and reset for all checks
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Bus answers and holding
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write got no response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read got no data");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == DRVPL_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");

    // ==========================================================
    // Clock control and rate strobe
    vco_mult_a: assert property (vco_enable == (pll_multiplier != 5'h01))
        else $error("oscillator power disagrees with multiplier");
    select_vco_a: assert property (select_vco |-> vco_enable)
        else $error("oscillator selected while powered down");
    strobe_single_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    zero_rate_a: assert property (combined_rate_word == 20'h0 [*2] |-> !sample_strobe)
        else $error("strobe with zero rate word");
    ref_toggle_a: assert property ($stable(pll_ref_clk) |=> $changed(pll_ref_clk))
        else $error("reference clock slower than a quarter");
endmodule

bind drvpl_top drvpl_monitor drvpl_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .combined_rate_word, .sample_strobe, .pll_ref_clk,
    .pll_multiplier, .vco_enable, .select_vco);

// [drvpl_top_test.sv]
// Purpose: Register-level tests of the rate, gain and PLL control block
// Assumes: 50 MHz aclk, AXI4-Lite master tasks
// Notes: Expected values are worked out from the register layout
`timescale 1ns/1ns
module drvpl_top_test import drvpl_pkg::*;;
    logic aclk = 0, aresetn = 0, pll_lock_in = 1;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_strobe, irq;
    logic pll_ref_clk, vco_enable, select_vco, oscillator_to_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [19:0] combined_rate_word;
    logic [15:0] left_out, right_out;
    logic [4:0] pll_multiplier;
    logic [29:0] regs [7] = '{DRVPL_IDX_RATE_LOW, DRVPL_IDX_RATE_HIGH, DRVPL_IDX_LEFT, DRVPL_IDX_RIGHT,
        DRVPL_IDX_GAIN, DRVPL_IDX_IRQ_STATUS, DRVPL_IDX_IRQ_MASK};
    int bad_count = 0, check_count = 0, n;

    drvpl_top drvpl_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_lock_in,
        .combined_rate_word, .sample_strobe, .left_out, .right_out, .pll_ref_clk, .pll_multiplier, .vco_enable,
        .select_vco, .oscillator_to_pin, .irq);

    // ==========================================================
    // Clock, compare and bus tasks
    always #10 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write one register and compare the response code
    task automatic wr(input logic [29:0] a, input logic [15:0] d, input logic [1:0] er);
        s_axi_awaddr <= {a, 2'h0};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            end
        end while (s_axi_bready);
    endtask

    // Read one register and compare data and response code
    task automatic rc(input logic [29:0] a, input logic [15:0] e, input logic [1:0] er);
        s_axi_araddr <= {a, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                chk("rdata", {16'h0, e}, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            end
        end while (s_axi_rready);
    endtask

    // Count reference clock changes over 16 cycles
    task automatic toggles(input int e);
        logic p;
        p = pll_ref_clk;
        n = 0;
        repeat (16) begin
            @(posedge aclk);
            if (pll_ref_clk !== p) n++;
            p = pll_ref_clk;
        end
        chk("ref toggles", 32'(e), 32'(n));
    endtask

    // Wait two strobes so new gain and samples have taken effect
    task automatic cap();
        repeat (2) begin
            do @(posedge aclk); while (sample_strobe !== 1'b1);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        #600000;
        bad_count++;
        give_verdict();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (regs[i]) rc(regs[i], 16'h0, DRVPL_RESP_OKAY);
        chk("mult", 32'h1, {27'h0, pll_multiplier});
        chk("vco", 32'h0, {31'h0, vco_enable});
        rc(30'h0000c020, 16'h0, DRVPL_RESP_SLVERR);
        wr(30'h0000c020, 16'h5a5a, DRVPL_RESP_SLVERR);
        wr(DRVPL_IDX_RATE_LOW, 16'h1234, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_RATE_HIGH, 16'h0005, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("rate word", 32'h51234, {12'h0, combined_rate_word});
        for (int k = 0; k < 16; k++) begin
            wr(DRVPL_IDX_RATE_HIGH, 16'h0200 | 16'(k << 4), DRVPL_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("mult", 32'(k + 1), {27'h0, pll_multiplier});
            chk("vco", 32'(k != 0), {31'h0, vco_enable});
            chk("select", 32'(k != 0), {31'h0, select_vco});
        end
        wr(DRVPL_IDX_RATE_HIGH, 16'h0950, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("select", 32'h0, {31'h0, select_vco});
        chk("vco pin", 32'h1, {31'h0, oscillator_to_pin});
        toggles(8);
        wr(DRVPL_IDX_RATE_HIGH, 16'h0000, DRVPL_RESP_OKAY);
        toggles(16);
        chk("vco pin", 32'h0, {31'h0, oscillator_to_pin});
        wr(DRVPL_IDX_RATE_LOW, 16'h0000, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_RATE_HIGH, 16'h0008, DRVPL_RESP_OKAY);
        n = 0;
        repeat (2560) begin
            @(posedge aclk);
            if (sample_strobe === 1'b1) n++;
        end
        chk("strobes near 10", 32'h1, 32'(n >= 9 && n <= 11));
        wr(DRVPL_IDX_LEFT, 16'h4000, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_RIGHT, 16'hc000, DRVPL_RESP_OKAY);
        rc(DRVPL_IDX_LEFT, 16'h4000, DRVPL_RESP_OKAY);
        rc(DRVPL_IDX_RIGHT, 16'hc000, DRVPL_RESP_OKAY);
        cap();
        chk("left", 32'h4000, {16'h0, left_out});
        chk("right", 32'hc000, {16'h0, right_out});
        wr(DRVPL_IDX_GAIN, 16'h0102, DRVPL_RESP_OKAY);
        cap();
        chk("left", 32'h2000, {16'h0, left_out});
        chk("right", 32'hf000, {16'h0, right_out});
        wr(DRVPL_IDX_LEFT, 16'h1000, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_RIGHT, 16'h1000, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_GAIN, 16'hb0f0, DRVPL_RESP_OKAY);
        cap();
        chk("fine clamp", {16'h0, left_out}, {16'h0, right_out});
        chk("fine top", 32'h1, 32'(left_out >= 16'd7714 && left_out <= 16'd7716));
        wr(DRVPL_IDX_RATE_HIGH, 16'hffff, DRVPL_RESP_OKAY);
        rc(DRVPL_IDX_RATE_HIGH, 16'h3bff, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_RATE_HIGH, 16'h0000, DRVPL_RESP_OKAY);
        rc(DRVPL_IDX_RATE_HIGH, 16'h2000, DRVPL_RESP_OKAY);
        pll_lock_in <= 1'b0;
        @(posedge aclk);
        pll_lock_in <= 1'b1;
        @(posedge aclk);
        rc(DRVPL_IDX_RATE_HIGH, 16'h0000, DRVPL_RESP_OKAY);
        rc(DRVPL_IDX_IRQ_STATUS, 16'h0003, DRVPL_RESP_OKAY);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(DRVPL_IDX_IRQ_MASK, 16'h0001, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(DRVPL_IDX_IRQ_STATUS, 16'h0001, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rc(DRVPL_IDX_IRQ_STATUS, 16'h0002, DRVPL_RESP_OKAY);
        wr(DRVPL_IDX_IRQ_MASK, 16'h0003, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(DRVPL_IDX_IRQ_STATUS, 16'h0002, DRVPL_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        give_verdict();
    end
endmodule
